/* shared/eqc_pkg.sv */
// constants and types for the channel 1 set b equalizer configuration bank
package eqc_pkg;

    localparam int BYTE_W    = 8;
    localparam int NUM_TAPS  = 7;
    localparam int NUM_REGS  = 10;
    localparam int TAP_MAG_W = 6;
    localparam int DRV_W     = 6;
    localparam int OFS_MAG_W = 5;
    localparam int AMP_W     = 3;

    // two-wire device address; value is arbitrary
    localparam logic [6:0] DEV_ADDR = 7'h2a;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // register offsets
    localparam logic [7:0] OFS_TAP2  = 8'h62;
    localparam logic [7:0] OFS_TAP3  = 8'h63;
    localparam logic [7:0] OFS_TAP4  = 8'h64;
    localparam logic [7:0] OFS_TAP5  = 8'h65;
    localparam logic [7:0] OFS_TAP6  = 8'h66;
    localparam logic [7:0] OFS_TAP7  = 8'h67;
    localparam logic [7:0] OFS_TAP8  = 8'h68;
    localparam logic [7:0] OFS_DRIVE = 8'h69;
    localparam logic [7:0] OFS_OFFS  = 8'h6a;
    localparam logic [7:0] OFS_AMP   = 8'h6b;

    // reset values
    localparam logic [7:0] RST_TAP2  = 8'hff;
    localparam logic [7:0] RST_TAP3  = 8'ha8;
    localparam logic [7:0] RST_TAP4  = 8'h84;
    localparam logic [7:0] RST_TAPZ  = 8'hc0;
    localparam logic [7:0] RST_DRIVE = 8'h3f;
    localparam logic [7:0] RST_OFFS  = 8'h40;
    localparam logic [7:0] RST_AMP   = 8'h04;

    // field positions
    localparam int TAP_EN_BIT   = 7;
    localparam int TAP_POS_BIT  = 6;
    localparam int OFS_AUTO_BIT = 6;
    localparam int OFS_SIGN_BIT = 5;

    // storage index of the non-tap registers
    localparam int IDX_DRIVE = 7;
    localparam int IDX_OFFS  = 8;
    localparam int IDX_AMP   = 9;

    localparam logic [7:0] REG_OFS [NUM_REGS] = '{OFS_TAP2, OFS_TAP3, OFS_TAP4,
        OFS_TAP5, OFS_TAP6, OFS_TAP7, OFS_TAP8, OFS_DRIVE, OFS_OFFS, OFS_AMP};
    localparam logic [7:0] REG_RST [NUM_REGS] = '{RST_TAP2, RST_TAP3, RST_TAP4,
        RST_TAPZ, RST_TAPZ, RST_TAPZ, RST_TAPZ, RST_DRIVE, RST_OFFS, RST_AMP};

    typedef enum logic [8:0] {
        ST_IDLE      = 9'h001,
        ST_ADDR      = 9'h002,
        ST_ADDR_ACK  = 9'h004,
        ST_PTR       = 9'h008,
        ST_PTR_ACK   = 9'h010,
        ST_WDATA     = 9'h020,
        ST_WDATA_ACK = 9'h040,
        ST_RDATA     = 9'h080,
        ST_RDATA_ACK = 9'h100
    } eqc_state_e;

endpackage

/* design/eqc_sync2.sv */
// two-flop synchroniser for the serial pins
`timescale 1ns/10ps
module eqc_sync2 #(
    parameter int         W       = 2,
    parameter logic [1:0] RST_VAL = 2'h3
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = d_i;
        sync_d = meta_q;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            meta_q <= RST_VAL[W-1:0];
            sync_q <= RST_VAL[W-1:0];
        end else if (ce_i) begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign q_o = sync_q;
endmodule

/* design/eqc_cfg_reg.sv */
// one 8-bit read/write configuration register with its reset default
`timescale 1ns/10ps
module eqc_cfg_reg #(
    parameter logic [7:0] RST_VAL = 8'h00
) (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    input  wire logic       we_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] q_o
);
    logic [7:0] val_q;
    logic [7:0] val_d;

    // every bit, factory bits included, takes the written value
    always_comb begin
        val_d = we_i ? wdata_i : val_q;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            val_q <= RST_VAL;
        end else if (ce_i) begin
            val_q <= val_d;
        end
    end

    assign q_o = val_q;

    a_write_lands: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ce_i && we_i |=> val_q == $past(wdata_i))
        else $error("register did not take written value");

    a_value_holds: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !(ce_i && we_i) |=> $stable(val_q))
        else $error("register changed without a write");
endmodule

/* design/eqc_cfg_top.sv */
// channel 1 set b equalizer configuration bank behind a two-wire slave
`timescale 1ns/10ps
// What this block does
// - tap register bit 6 selects polarity, one positive, zero negative.
// - tap register bit 7 enables the tap, resets to one.
// - tap register low six bits hold unsigned gain magnitude.
// - tap 2 resets enabled, positive, full-scale magnitude.
// - tap 3 resets enabled, negative, magnitude 0x28.
// - tap 4 resets enabled, negative, magnitude 0x04.
// - taps 5 to 8 reset enabled, positive, zero magnitude.
// - predriver gain in six low bits, resets full scale; top bits zero.
// - offset bit 6 is auto correction enable resetting one; bit 7 zero.
// - offset bit 5 manual sign, low five bits manual magnitude, reset zero.
// - amplitude register low three bits target code, reset 100; rest zero.
// - every field including factory bits reads back last write or default.
module eqc_cfg_top (
    input  wire logic                                   ref_clk_i,
    input  wire logic                                   rst_n_i,
    input  wire logic                                   ce_i,
    input  wire logic                                   scl_i,
    input  wire logic                                   sda_i,
    output logic                                        sda_o,
    output logic                                        sda_oe_o,
    output logic [eqc_pkg::NUM_TAPS-1:0]                tap_en_o,
    output logic [eqc_pkg::NUM_TAPS-1:0]                tap_pos_o,
    output logic [eqc_pkg::NUM_TAPS-1:0][eqc_pkg::TAP_MAG_W-1:0] tap_mag_o,
    output logic [eqc_pkg::DRV_W-1:0]                   drive_gain_o,
    output logic                                        offset_auto_en_o,
    output logic                                        offset_manual_sign_o,
    output logic [eqc_pkg::OFS_MAG_W-1:0]               offset_manual_mag_o,
    output logic [eqc_pkg::AMP_W-1:0]                   gain_ctrl_target_level_o
);
    import eqc_pkg::*;

    logic [1:0]       pins_s;
    logic             scl_s;
    logic             sda_s;
    logic             scl_p_q;
    logic             scl_p_d;
    logic             sda_p_q;
    logic             sda_p_d;
    logic             scl_rise;
    logic             scl_fall;
    logic             start_cond;
    logic             stop_cond;

    eqc_state_e       state_q;
    eqc_state_e       state_d;
    logic [7:0]       shift_q;
    logic [7:0]       shift_d;
    logic [3:0]       cnt_q;
    logic [3:0]       cnt_d;
    logic [7:0]       ptr_q;
    logic [7:0]       ptr_d;
    logic             rw_q;
    logic             rw_d;
    logic             oe_q;
    logic             oe_d;
    logic             sda_q;
    logic             sda_d;
    logic             wr_stb;
    logic [7:0]       rdata;

    logic [NUM_REGS-1:0] reg_we;
    logic [7:0]          reg_q [NUM_REGS];

    logic             man_sign_q;
    logic             man_sign_d;
    logic [OFS_MAG_W-1:0] man_mag_q;
    logic [OFS_MAG_W-1:0] man_mag_d;

    function automatic logic reg_hit(input logic [7:0] addr, input int idx);
        reg_hit = (addr == REG_OFS[idx]);
    endfunction

    // pins from outside the clock domain
    eqc_sync2 #(
        .W       (2),
        .RST_VAL (2'h3)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .ce_i      (ce_i),
        .d_i       ({scl_i, sda_i}),
        .q_o       (pins_s)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    always_comb begin
        scl_p_d    = scl_s;
        sda_p_d    = sda_s;
        scl_rise   = scl_s && !scl_p_q;
        scl_fall   = !scl_s && scl_p_q;
        start_cond = scl_s && scl_p_q && sda_p_q && !sda_s;
        stop_cond  = scl_s && scl_p_q && !sda_p_q && sda_s;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else if (ce_i) begin
            scl_p_q <= scl_p_d;
            sda_p_q <= sda_p_d;
        end
    end

    // unmapped offsets read as zero
    always_comb begin
        rdata = 8'h00;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (reg_hit(ptr_q, i)) begin
                rdata = reg_q[i];
            end
        end
    end

    // serial slave: address, pointer (writes only), then auto-incrementing data bytes
    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        cnt_d   = cnt_q;
        ptr_d   = ptr_q;
        rw_d    = rw_q;
        oe_d    = oe_q;
        sda_d   = 1'b0;
        wr_stb  = 1'b0;
        if (start_cond) begin
            state_d = ST_ADDR;
            cnt_d   = 4'h0;
            oe_d    = 1'b0;
        end else if (stop_cond) begin
            state_d = ST_IDLE;
            oe_d    = 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    oe_d = 1'b0;
                end
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (scl_rise) begin
                        shift_d = {shift_q[6:0], sda_s};
                        cnt_d   = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                        cnt_d = 4'h0;
                        oe_d  = 1'b1;
                        if (state_q == ST_ADDR) begin
                            if (shift_q[7:1] == DEV_ADDR) begin
                                rw_d    = shift_q[0];
                                state_d = ST_ADDR_ACK;
                            end else begin
                                oe_d    = 1'b0;
                                state_d = ST_IDLE;
                            end
                        end else if (state_q == ST_PTR) begin
                            ptr_d   = shift_q;
                            state_d = ST_PTR_ACK;
                        end else begin
                            wr_stb  = 1'b1;
                            ptr_d   = ptr_q + 8'h01;
                            state_d = ST_WDATA_ACK;
                        end
                    end
                end
                ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        oe_d = 1'b0;
                        if (state_q == ST_ADDR_ACK && rw_q) begin
                            state_d = ST_RDATA;
                            shift_d = rdata;
                            oe_d    = !rdata[7];
                        end else if (state_q == ST_ADDR_ACK) begin
                            state_d = ST_PTR;
                        end else begin
                            state_d = ST_WDATA;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_rise) begin
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                        oe_d    = 1'b0;
                        cnt_d   = 4'h0;
                        ptr_d   = ptr_q + 8'h01;
                        state_d = ST_RDATA_ACK;
                    end else if (scl_fall) begin
                        shift_d = {shift_q[6:0], 1'b0};
                        oe_d    = !shift_q[6];
                    end
                end
                ST_RDATA_ACK: begin
                    if (scl_rise && sda_s) begin
                        state_d = ST_IDLE;
                    end else if (scl_fall) begin
                        state_d = ST_RDATA;
                        shift_d = rdata;
                        oe_d    = !rdata[7];
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                    oe_d    = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            shift_q <= 8'h00;
            cnt_q   <= 4'h0;
            ptr_q   <= 8'h00;
            rw_q    <= 1'b0;
            oe_q    <= 1'b0;
            sda_q   <= 1'b0;
        end else if (ce_i) begin
            state_q <= state_d;
            shift_q <= shift_d;
            cnt_q   <= cnt_d;
            ptr_q   <= ptr_d;
            rw_q    <= rw_d;
            oe_q    <= oe_d;
            sda_q   <= sda_d;
        end
    end

    assign sda_o    = sda_q;
    assign sda_oe_o = oe_q;

    // register storage
    for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
        assign reg_we[g] = wr_stb && reg_hit(ptr_q, g);
        eqc_cfg_reg #(
            .RST_VAL (REG_RST[g])
        ) u_reg (
            .ref_clk_i (ref_clk_i),
            .rst_n_i   (rst_n_i),
            .ce_i      (ce_i),
            .we_i      (reg_we[g]),
            .wdata_i   (shift_q),
            .q_o       (reg_q[g])
        );
    end

    // tap fields straight from the register flops
    for (genvar t = 0; t < NUM_TAPS; t++) begin : g_tap
        assign tap_en_o[t]  = reg_q[t][TAP_EN_BIT];
        assign tap_pos_o[t] = reg_q[t][TAP_POS_BIT];
        assign tap_mag_o[t] = reg_q[t][TAP_MAG_W-1:0];
    end

    assign drive_gain_o             = reg_q[IDX_DRIVE][DRV_W-1:0];
    assign offset_auto_en_o         = reg_q[IDX_OFFS][OFS_AUTO_BIT];
    assign gain_ctrl_target_level_o = reg_q[IDX_AMP][AMP_W-1:0];

    // manual offset is masked while automatic correction runs
    always_comb begin
        man_sign_d = 1'b0;
        man_mag_d  = '0;
        if (!reg_q[IDX_OFFS][OFS_AUTO_BIT]) begin
            man_sign_d = reg_q[IDX_OFFS][OFS_SIGN_BIT];
            man_mag_d  = reg_q[IDX_OFFS][OFS_MAG_W-1:0];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            man_sign_q <= 1'b0;
            man_mag_q  <= '0;
        end else if (ce_i) begin
            man_sign_q <= man_sign_d;
            man_mag_q  <= man_mag_d;
        end
    end

    assign offset_manual_sign_o = man_sign_q;
    assign offset_manual_mag_o  = man_mag_q;

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_tap2_reset: assert property ($rose(rst_n_i) |->
        tap_en_o[0] && tap_pos_o[0] && tap_mag_o[0] == 6'h3f)
        else $error("tap 2 reset value wrong");

    a_tap3_reset: assert property ($rose(rst_n_i) |->
        tap_en_o[1] && !tap_pos_o[1] && tap_mag_o[1] == 6'h28)
        else $error("tap 3 reset value wrong");

    a_tap4_reset: assert property ($rose(rst_n_i) |->
        tap_en_o[2] && !tap_pos_o[2] && tap_mag_o[2] == 6'h04)
        else $error("tap 4 reset value wrong");

    a_zero_taps_reset: assert property ($rose(rst_n_i) |->
        tap_en_o[6:3] == 4'hf && tap_pos_o[6:3] == 4'hf
        && tap_mag_o[6:3] == 24'h000000)
        else $error("taps 5 to 8 reset value wrong");

    a_drive_reset: assert property ($rose(rst_n_i) |->
        reg_q[IDX_DRIVE] == 8'h3f && drive_gain_o == 6'h3f)
        else $error("predriver reset value wrong");

    a_offset_reset: assert property ($rose(rst_n_i) |->
        reg_q[IDX_OFFS] == 8'h40 && offset_auto_en_o)
        else $error("offset reset value wrong");

    a_amp_reset: assert property ($rose(rst_n_i) |->
        reg_q[IDX_AMP] == 8'h04 && gain_ctrl_target_level_o == 3'h4)
        else $error("amplitude reset value wrong");

    a_tap_polarity_write: assert property (ce_i && reg_we[1] |=>
        tap_pos_o[1] == $past(shift_q[6]) && tap_en_o[1] == $past(shift_q[7])
        && tap_mag_o[1] == $past(shift_q[5:0]))
        else $error("tap 3 fields do not follow write");

    a_manual_masked: assert property (ce_i && offset_auto_en_o |=>
        !offset_manual_sign_o && offset_manual_mag_o == 5'h00)
        else $error("manual offset leaked while automatic");

    a_manual_passes: assert property (ce_i && !offset_auto_en_o |=>
        offset_manual_mag_o == $past(reg_q[IDX_OFFS][4:0]))
        else $error("manual offset not passed");

    a_unmapped_read: assert property (state_q == ST_RDATA_ACK && scl_fall && ce_i
        && !stop_cond && !start_cond && (ptr_q < OFS_TAP2 || ptr_q > OFS_AMP) |=> shift_q == 8'h00)
        else $error("unmapped offset read nonzero");

    c_tap_write: cover property (ce_i && reg_we[0]);
    c_read_byte: cover property (state_q == ST_RDATA_ACK);
    c_auto_off: cover property (!offset_auto_en_o);
    c_addr_ack: cover property (state_q == ST_ADDR_ACK && oe_q);
endmodule

/* verification/eqc_cfg_top_tb.sv */
// self-checking bench for the channel 1 set b equalizer configuration bank
`timescale 1ns/10ps
module eqc_cfg_top_tb;
    import eqc_pkg::*;

    localparam int H = 8;

    logic                               ref_clk;
    logic                               rst_n;
    logic                               ce;
    logic                               scl;
    logic                               sda_m;
    logic                               sda_w;
    logic                               sda_o;
    logic                               sda_oe;
    logic [NUM_TAPS-1:0]                tap_en;
    logic [NUM_TAPS-1:0]                tap_pos;
    logic [NUM_TAPS-1:0][TAP_MAG_W-1:0] tap_mag;
    logic [DRV_W-1:0]                   drv;
    logic                               ofs_auto;
    logic                               ofs_sign;
    logic [OFS_MAG_W-1:0]               ofs_mag;
    logic [AMP_W-1:0]                   amp;
    logic [7:0]                         exp_q [NUM_REGS];
    logic [7:0]                         wbuf  [NUM_REGS];
    int                                 fails;
    int                                 compares;

    // open-drain wire: device can only pull low
    assign sda_w = sda_oe ? (sda_o & sda_m) : sda_m;

    eqc_cfg_top eqc_cfg_top_inst (
        .ref_clk_i               (ref_clk),
        .rst_n_i                 (rst_n),
        .ce_i                    (ce),
        .scl_i                   (scl),
        .sda_i                   (sda_w),
        .sda_o                   (sda_o),
        .sda_oe_o                (sda_oe),
        .tap_en_o                (tap_en),
        .tap_pos_o               (tap_pos),
        .tap_mag_o               (tap_mag),
        .drive_gain_o            (drv),
        .offset_auto_en_o        (ofs_auto),
        .offset_manual_sign_o    (ofs_sign),
        .offset_manual_mag_o     (ofs_mag),
        .gain_ctrl_target_level_o(amp)
    );

    always #2 ref_clk = ~ref_clk;

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic chk_bit(input string what, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        rst_n = 1'b0;
        tick(4);
        rst_n = 1'b1;
        tick(4);
        exp_q = '{8'hff, 8'ha8, 8'h84, 8'hc0, 8'hc0, 8'hc0, 8'hc0, 8'h3f, 8'h40, 8'h04};
    endtask

    task automatic start_cond();
        sda_m = 1'b1;
        tick(H);
        scl = 1'b1;
        tick(H);
        sda_m = 1'b0;
        tick(H);
        scl = 1'b0;
        tick(2);
    endtask

    task automatic stop_cond();
        sda_m = 1'b0;
        tick(H);
        scl = 1'b1;
        tick(H);
        sda_m = 1'b1;
        tick(H);
    endtask

    task automatic put_bit(input logic b);
        sda_m = b;
        tick(H);
        scl = 1'b1;
        tick(H);
        scl = 1'b0;
        tick(2);
    endtask

    task automatic get_bit(output logic b);
        sda_m = 1'b1;
        tick(H);
        scl = 1'b1;
        tick(H);
        b = sda_w;
        scl = 1'b0;
        tick(2);
    endtask

    task automatic send_byte(input logic [7:0] d, input logic ack, input string what);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i]);
        end
        get_bit(a);
        chk_bit(what, ~ack, a);
    endtask

    task automatic recv_byte(output logic [7:0] d, input logic last);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            get_bit(b);
            d[i] = b;
        end
        put_bit(last);
    endtask

    task automatic wr_regs(input logic [7:0] ptr, input int n);
        int idx;
        start_cond();
        send_byte({DEV_ADDR, 1'b0}, 1'b1, "address ack");
        send_byte(ptr, 1'b1, "pointer ack");
        for (int k = 0; k < n; k++) begin
            send_byte(wbuf[k], 1'b1, "data ack");
            idx = int'(ptr) + k - int'(OFS_TAP2);
            if (idx >= 0 && idx < NUM_REGS) begin
                exp_q[idx] = wbuf[k];
            end
        end
        stop_cond();
    endtask

    task automatic rd_check(input logic [7:0] ptr, input int n);
        logic [7:0] d;
        logic [7:0] e;
        int         idx;
        start_cond();
        send_byte({DEV_ADDR, 1'b0}, 1'b1, "address ack");
        send_byte(ptr, 1'b1, "pointer ack");
        start_cond();
        send_byte({DEV_ADDR, 1'b1}, 1'b1, "read address ack");
        for (int k = 0; k < n; k++) begin
            recv_byte(d, k == n - 1);
            idx = int'(ptr) + k - int'(OFS_TAP2);
            e = (idx >= 0 && idx < NUM_REGS) ? exp_q[idx] : 8'h00;
            chk_byte("register read", e, d);
        end
        stop_cond();
    endtask

    task automatic check_outputs();
        logic man;
        man = ~exp_q[IDX_OFFS][6];
        for (int i = 0; i < NUM_TAPS; i++) begin
            chk_bit("tap enable", exp_q[i][7], tap_en[i]);
            chk_bit("tap polarity", exp_q[i][6], tap_pos[i]);
            chk_byte("tap magnitude", {2'h0, exp_q[i][5:0]}, {2'h0, tap_mag[i]});
        end
        chk_byte("drive gain", {2'h0, exp_q[IDX_DRIVE][5:0]}, {2'h0, drv});
        chk_bit("offset auto", exp_q[IDX_OFFS][6], ofs_auto);
        chk_bit("offset sign", man & exp_q[IDX_OFFS][5], ofs_sign);
        chk_byte("offset mag", {3'h0, exp_q[IDX_OFFS][4:0] & {5{man}}}, {3'h0, ofs_mag});
        chk_byte("target level", {5'h00, exp_q[IDX_AMP][2:0]}, {5'h00, amp});
    endtask

    task automatic sc_defaults();
        check_outputs();
        rd_check(OFS_TAP2, NUM_REGS);
    endtask

    task automatic sc_write_all();
        // factory bits written only with their defaults
        wbuf = '{8'h5a, 8'h3c, 8'h81, 8'h07, 8'he6, 8'h40, 8'h19, 8'h15, 8'h35, 8'h03};
        wr_regs(OFS_TAP2, NUM_REGS);
        check_outputs();
        rd_check(OFS_TAP2, NUM_REGS);
    endtask

    task automatic sc_offset_mask();
        wbuf[0] = 8'h5f;
        wr_regs(OFS_OFFS, 1);
        check_outputs();
        wbuf[0] = 8'h2a;
        wr_regs(OFS_OFFS, 1);
        check_outputs();
        rd_check(OFS_OFFS, 1);
    endtask

    task automatic sc_refused();
        start_cond();
        send_byte({DEV_ADDR ^ 7'h01, 1'b0}, 1'b0, "foreign address ack");
        stop_cond();
        wbuf[0] = 8'h05;
        wbuf[1] = 8'hee;
        wr_regs(OFS_AMP, 2);
        rd_check(OFS_AMP, 2);
        rd_check(8'h70, 1);
        check_outputs();
    endtask

    // clock enable low: no ack, no write, state frozen at idle
    task automatic sc_ce_freeze();
        ce = 1'b0;
        start_cond();
        send_byte({DEV_ADDR, 1'b0}, 1'b0, "frozen address ack");
        send_byte(OFS_TAP2, 1'b0, "frozen pointer ack");
        send_byte(8'h11, 1'b0, "frozen data ack");
        stop_cond();
        ce = 1'b1;
        tick(4);
        check_outputs();
        rd_check(OFS_TAP2, 1);
    endtask

    task automatic sc_mid_reset();
        do_reset();
        check_outputs();
        rd_check(OFS_TAP2, NUM_REGS);
    endtask

    initial begin
        ref_clk  = 1'b0;
        rst_n    = 1'b0;
        ce       = 1'b1;
        scl      = 1'b1;
        sda_m    = 1'b1;
        fails    = 0;
        compares = 0;
        do_reset();
        sc_defaults();
        sc_write_all();
        sc_offset_mask();
        sc_refused();
        sc_ce_freeze();
        sc_mid_reset();
        finish_test();
    end

    initial begin
        repeat (100000) @(posedge ref_clk);
        fails++;
        $display("wrong value run length expected done seen hang");
        finish_test();
    end

endmodule
